// ### common/ubei_pkg.sv
package ubei_pkg;

	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADR_W  = 8;
	localparam int unsigned SEL_W  = 4;
	localparam int unsigned REG_W  = 8;
	localparam int unsigned EVT_N  = 4;
	localparam int unsigned IDX_W  = 6;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_STATUS  = 6'h0a;
	localparam logic [IDX_W-1:0] IDX_ENABLE  = 6'h0b;
	localparam logic [IDX_W-1:0] IDX_LINK    = 6'h10;
	localparam logic [IDX_W-1:0] IDX_OVERRUN = 6'h11;

	// Field positions shared by status, enable and overrun registers.
	localparam int unsigned BIT_SUSPEND = 0;
	localparam int unsigned BIT_RESUME  = 1;
	localparam int unsigned BIT_RESET   = 2;
	localparam int unsigned BIT_SOF     = 3;

	// Field positions of the link state register.
	localparam int unsigned LINK_SUSPENDED = 0;
	localparam int unsigned LINK_IRQ       = 1;
	localparam int unsigned LINK_RAW_LSB   = 4;

	// Values after reset, and the mask of the four event bits.
	localparam logic [REG_W-1:0] STATUS_RST  = 8'h00;
	localparam logic [REG_W-1:0] ENABLE_RST  = 8'h06;
	localparam logic [REG_W-1:0] OVERRUN_RST = 8'h00;
	localparam logic [REG_W-1:0] EVT_MASK    = 8'h0f;

	// Cycles from a taken request to its acknowledge.
	localparam int unsigned ACK_CYCLES = 1;

	typedef struct packed {
		logic sof;
		logic bus_reset;
		logic resume;
		logic suspend;
	} ubei_evt_t;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [ADR_W-1:0]  adr;
		logic [DATA_W-1:0] dat;
		logic [SEL_W-1:0]  sel;
	} ubei_wb_req_t;

	typedef enum {
		ST_AWAKE,
		ST_ASLEEP
	} ubei_link_st_t;

endpackage

// ### rtl/ubei_edge_pulse.sv
// Turns event levels from the bus side into one-cycle pulses on their rising edge.
module ubei_edge_pulse #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] level_i,
	output logic      [WIDTH-1:0] pulse_o
);

	logic [WIDTH-1:0] level_q;

	initial begin
		if (WIDTH < 1) begin
			$error("ubei_edge_pulse: WIDTH must be at least one");
		end
	end

	// A level held across reset release is reported as a fresh event, since level_q resets to zero.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= '0;
		end else begin
			level_q <= level_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_o <= '0;
		end else begin
			pulse_o <= level_i & ~level_q;
		end
	end

endmodule

// ### rtl/ubei_top.sv
// Behaviour
// RULE1 - An 8-bit status register shows pending bus events; it resets to zero.
// RULE2 - Reading the status register returns the flags and clears those returned.
// RULE3 - Status bit 3 is set when a new frame starts on the bus.
// RULE4 - Status bit 2 is set when bus reset signalling is detected.
// RULE5 - Status bit 1 is set on resume signalling, only while suspended.
// RULE6 - Resume flag comes only from clocked logic; clockless wake is elsewhere.
// RULE7 - Status bit 0 is set when suspend signalling is detected.
// RULE8 - Status bits 7 to 4 are reserved and read as zero.
// RULE9 - An 8-bit read/write enable register mirrors the status layout.
// RULE10 - The interrupt request is raised for each flag set with its enable one.
// RULE11 - The enable register resets to 0x06, enabling reset and resume only.
// RULE12 - Flags are recorded whatever the enable; masking only blocks the request.
//
// Our own choice: the Wishbone register port.
module ubei_top #(
	parameter int unsigned EVT_N = ubei_pkg::EVT_N,
	parameter int unsigned ADR_W = ubei_pkg::ADR_W
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_i,
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [ADR_W-1:0]            wb_adr_i,
	input  wire logic [ubei_pkg::DATA_W-1:0] wb_dat_i,
	input  wire logic [ubei_pkg::SEL_W-1:0]  wb_sel_i,
	output logic      [ubei_pkg::DATA_W-1:0] wb_dat_o,
	output logic                             wb_ack_o,
	input  wire ubei_pkg::ubei_evt_t         bus_evt_i,
	output logic                             irq_o,
	output logic                             suspended_o
);

	ubei_pkg::ubei_wb_req_t      req;
	ubei_pkg::ubei_evt_t         evt_pulse;
	ubei_pkg::ubei_link_st_t     link_st;
	ubei_pkg::ubei_link_st_t     next_link_st;
	logic [ubei_pkg::REG_W-1:0]  status;
	logic [ubei_pkg::REG_W-1:0]  enable;
	logic [ubei_pkg::REG_W-1:0]  next_enable;
	logic [ubei_pkg::REG_W-1:0]  overrun;
	logic [ubei_pkg::REG_W-1:0]  next_status;
	logic [ubei_pkg::REG_W-1:0]  next_overrun;
	logic [ubei_pkg::REG_W-1:0]  evt_set;
	logic [ubei_pkg::REG_W-1:0]  status_clr;
	logic [ubei_pkg::REG_W-1:0]  overrun_clr;
	logic [ubei_pkg::REG_W-1:0]  rd_word;
	logic [ubei_pkg::REG_W-1:0]  rd_snap;
	logic [ubei_pkg::IDX_W-1:0]  req_idx;
	logic                        req_live;
	logic                        ack_edge;
	logic                        rd_status;
	logic                        rd_overrun;
	logic                        wr_enable;

	initial begin
		if (EVT_N != ubei_pkg::EVT_N) begin
			$error("ubei_top: the event set has exactly four members");
		end
		if (ADR_W < ubei_pkg::IDX_W + 2) begin
			$error("ubei_top: ADR_W too narrow for the register map");
		end
	end

	// Turns a byte address into a register index; the two low bits are ignored.
	function automatic logic [ubei_pkg::IDX_W-1:0] word_index(
		input logic [ADR_W-1:0] adr
	);
		word_index = adr[ubei_pkg::IDX_W+1:2];
	endfunction

	// Compares the request with one register and qualifies it with the bus cycle.
	function automatic logic hits(
		input logic [ubei_pkg::IDX_W-1:0] idx,
		input logic [ubei_pkg::IDX_W-1:0] target,
		input logic                       live
	);
		hits = live && (idx == target);
	endfunction

	assign req.cyc = wb_cyc_i;
	assign req.stb = wb_stb_i;
	assign req.we  = wb_we_i;
	assign req.adr = wb_adr_i;
	assign req.dat = wb_dat_i;
	assign req.sel = wb_sel_i;

	assign req_live = req.cyc && req.stb;
	assign req_idx  = word_index(req.adr);

	// The acknowledge follows one cycle after the request and lasts one cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req_live && !wb_ack_o;
		end
	end

	// Writes and read side effects act only at the edge where the master sees ack.
	assign ack_edge   = wb_ack_o && req_live;
	assign rd_status  = hits(req_idx, ubei_pkg::IDX_STATUS, ack_edge) && !req.we;
	assign rd_overrun = hits(req_idx, ubei_pkg::IDX_OVERRUN, ack_edge) && !req.we;
	assign wr_enable  = hits(req_idx, ubei_pkg::IDX_ENABLE, ack_edge) && req.we
		&& req.sel[0];

	// Bus event levels become pulses; the whole path runs on clk_i.
	ubei_edge_pulse #(
		.WIDTH(EVT_N)
	) u_edge (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.level_i(bus_evt_i),
		.pulse_o(evt_pulse)
	);

	always_comb begin
		next_link_st = link_st;
		case (link_st)
			ubei_pkg::ST_AWAKE: begin
				if (evt_pulse.suspend && !evt_pulse.bus_reset) begin
					next_link_st = ubei_pkg::ST_ASLEEP;
				end
			end
			ubei_pkg::ST_ASLEEP: begin
				if (evt_pulse.resume || evt_pulse.bus_reset || evt_pulse.sof) begin
					next_link_st = ubei_pkg::ST_AWAKE;
				end
			end
			default: begin
				next_link_st = ubei_pkg::ST_AWAKE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link_st <= ubei_pkg::ST_AWAKE;
		end else begin
			link_st <= next_link_st;
		end
	end

	assign suspended_o = (link_st == ubei_pkg::ST_ASLEEP);

	// Event set vector in register layout; the enable mask plays no part here.
	always_comb begin
		evt_set = '0;
		evt_set[ubei_pkg::BIT_SOF]     = evt_pulse.sof; // RULE3 RULE12
		evt_set[ubei_pkg::BIT_RESET]   = evt_pulse.bus_reset; // RULE4 RULE12
		// Resume is qualified by the clocked link state, so a stopped clk_i
		// cannot report it; a clockless wake path must do that job.
		evt_set[ubei_pkg::BIT_RESUME]  = evt_pulse.resume && suspended_o; // RULE5 RULE6
		evt_set[ubei_pkg::BIT_SUSPEND] = evt_pulse.suspend; // RULE7 RULE12
	end

	// Only the bits returned by the read are cleared, so an event landing
	// between capture and clear is kept for the next read.
	assign status_clr  = rd_status ? rd_snap : '0; // RULE2
	assign overrun_clr = rd_overrun ? rd_snap : '0;

	// A set in the clearing cycle wins over the clear.
	assign next_status  = ((status & ~status_clr) | evt_set) & ubei_pkg::EVT_MASK; // RULE8
	assign next_overrun = ((overrun & ~overrun_clr) | (evt_set & status & ~status_clr))
		& ubei_pkg::EVT_MASK;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status <= ubei_pkg::STATUS_RST; // RULE1
		end else begin
			status <= next_status; // RULE1
		end
	end

	// Flags, per event bit, an event that arrived while its flag was still pending.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overrun <= ubei_pkg::OVERRUN_RST;
		end else begin
			overrun <= next_overrun;
		end
	end

	// The request follows a new mask in the same edge as the write lands.
	always_comb begin
		next_enable = enable;
		if (wr_enable) begin
			next_enable = req.dat[ubei_pkg::REG_W-1:0] & ubei_pkg::EVT_MASK; // RULE9 RULE8
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable <= ubei_pkg::ENABLE_RST; // RULE11
		end else begin
			enable <= next_enable; // RULE9
		end
	end

	// Level request, high while any enabled flag is pending.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(next_status & next_enable); // RULE10
		end
	end

	always_comb begin
		rd_word = '0;
		case (req_idx)
			ubei_pkg::IDX_STATUS: begin
				rd_word = status & ubei_pkg::EVT_MASK; // RULE2 RULE8
			end
			ubei_pkg::IDX_ENABLE: begin
				rd_word = enable & ubei_pkg::EVT_MASK; // RULE9
			end
			ubei_pkg::IDX_LINK: begin
				rd_word[ubei_pkg::LINK_SUSPENDED] = suspended_o;
				rd_word[ubei_pkg::LINK_IRQ]       = irq_o;
				rd_word[ubei_pkg::LINK_RAW_LSB +: 4] = bus_evt_i;
			end
			ubei_pkg::IDX_OVERRUN: begin
				rd_word = overrun;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Read data is captured with the acknowledge and held steady for the master.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_snap <= '0;
		end else if (req_live && !wb_ack_o && !req.we) begin
			rd_snap <= rd_word;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (req_live && !wb_ack_o && !req.we) begin
			wb_dat_o <= {{(ubei_pkg::DATA_W-ubei_pkg::REG_W){1'b0}}, rd_word};
		end else begin
			wb_dat_o <= '0;
		end
	end

endmodule

// ### verification/ubei_host_model.sv
module ubei_host_model (
	input  wire logic           clk_i,
	output ubei_pkg::ubei_evt_t evt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial evt_o = '0;
	// The device counts rising edges, so each event is one short level that then returns low.
	task automatic emit(input int b);
		@(posedge clk_i);
		evt_o[b] <= 1'b1;
		repeat (2) @(posedge clk_i);
		evt_o[b] <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
endmodule

// ### verification/ubei_top_asserts.sv
module ubei_top_asserts #(
	parameter int unsigned EVT_N = ubei_pkg::EVT_N,
	parameter int unsigned ADR_W = ubei_pkg::ADR_W
) (
	input wire logic                        clk_i,
	input wire logic                        rst_i,
	input wire logic                        wb_cyc_i,
	input wire logic                        wb_stb_i,
	input wire logic                        wb_we_i,
	input wire logic [ADR_W-1:0]            wb_adr_i,
	input wire logic [ubei_pkg::DATA_W-1:0] wb_dat_i,
	input wire logic [ubei_pkg::SEL_W-1:0]  wb_sel_i,
	input wire logic [ubei_pkg::DATA_W-1:0] wb_dat_o,
	input wire logic                        wb_ack_o,
	input wire ubei_pkg::ubei_evt_t         bus_evt_i,
	input wire logic                        irq_o,
	input wire logic                        suspended_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_lat_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	rsvd_zero_a: assert property (wb_ack_o && wb_adr_i[7:3] == 5'h05 |-> wb_dat_o[31:4] == 28'h0)
		else $error("reserved bits set");
	susp_set_a: assert property ($rose(bus_evt_i.suspend) && bus_evt_i[3:1] == 3'h0 |-> ##2 suspended_o)
		else $error("suspend not entered");
	wake_clr_a: assert property ($rose(bus_evt_i.bus_reset) && !$rose(bus_evt_i.suspend)
		|-> ##2 !suspended_o)
		else $error("suspend not left");
	irq_cause_a: assert property ($rose(irq_o) |-> ($past(bus_evt_i, 2) & ~$past(bus_evt_i, 3)) != 4'h0
		|| $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("irq without cause");
	irq_drop_a: assert property ($fell(irq_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("irq dropped without access");
	cover property (irq_o);
	cover property (suspended_o);
	cover property (wb_ack_o && wb_dat_o != 32'h0);
endmodule

bind ubei_top ubei_top_asserts #(.EVT_N(EVT_N), .ADR_W(ADR_W)) u_ubei_top_asserts (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .bus_evt_i(bus_evt_i), .irq_o(irq_o), .suspended_o(suspended_o));

// ### verification/ubei_top_tb.sv
module ubei_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic                clk_i = 1'b0;
	logic                rst_i = 1'b1;
	logic                cyc   = 1'b0;
	logic                stb   = 1'b0;
	logic                we    = 1'b0;
	logic [7:0]          adr   = 8'h00;
	logic [31:0]         dat   = 32'h0;
	logic [3:0]          sel   = 4'h0;
	logic [31:0]         dat_o;
	logic                ack;
	logic                irq;
	logic                susp;
	ubei_pkg::ubei_evt_t evt;
	int                  fail_count = 0;
	int                  checks     = 0;

	initial forever #25 clk_i = ~clk_i;

	ubei_top u_ubei_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .bus_evt_i(evt), .irq_o(irq), .suspended_o(susp));
	ubei_host_model u_ubei_host_model (.clk_i(clk_i), .evt_o(evt));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 100);
		if (ack !== 1'b1) fail_count++;
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	// Irq lags a register write by up to two edges, so the check waits past that.
	task automatic ci(input logic exp);
		repeat (3) @(posedge clk_i);
		chk(32'(irq), 32'(exp));
	endtask

	task automatic final_report;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge clk_i);
		fail_count++;
		final_report;
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h28, 32'h00);
		rd(8'h2c, 32'h06);
		rd(8'h00, 32'h00);
		wr(8'h28, 32'hff);
		rd(8'h28, 32'h00);
		u_ubei_host_model.emit(ubei_pkg::BIT_SUSPEND);
		chk(32'(susp), 32'h1);
		rd(8'h40, 32'h01);
		ci(1'b0);
		rd(8'h28, 32'h01);
		rd(8'h28, 32'h00);
		u_ubei_host_model.emit(ubei_pkg::BIT_RESUME);
		ci(1'b1);
		rd(8'h28, 32'h02);
		ci(1'b0);
		u_ubei_host_model.emit(ubei_pkg::BIT_RESUME);
		rd(8'h28, 32'h00);
		u_ubei_host_model.emit(ubei_pkg::BIT_RESET);
		ci(1'b1);
		rd(8'h28, 32'h04);
		u_ubei_host_model.emit(ubei_pkg::BIT_SOF);
		ci(1'b0);
		wr(8'h2c, 32'hff);
		rd(8'h2c, 32'h0f);
		ci(1'b1);
		wr(8'h2c, 32'h00);
		ci(1'b0);
		u_ubei_host_model.emit(ubei_pkg::BIT_SOF);
		rd(8'h44, 32'h08);
		rd(8'h28, 32'h08);
		final_report;
	end
endmodule
